// File: hw/pli_pkg.sv
package pli_pkg;
	// register indices on the management serial bus
	localparam logic [4:0] ADR_FNSEL = 5'h16;
	localparam logic [4:0] ADR_BEHAV = 5'h17;
	localparam logic [4:0] ADR_DRIVE = 5'h19;
	localparam logic [4:0] ADR_LEGACY = 5'h1a;
	localparam logic [4:0] ADR_EVENT = 5'h1b;
	localparam logic [4:0] ADR_CTRL = 5'h1f;
	// reset values
	localparam logic [15:0] RST_FNSEL = 16'h0021;
	localparam logic [15:0] RST_BEHAV = 16'h1000;
	localparam logic [15:0] RST_DRIVE = 16'h0000;
	localparam logic [15:0] RST_LEGACY = 16'h4000;
	localparam logic [7:0] RST_EVEN = 8'h00;
	localparam logic [7:0] RST_EVST = 8'h00;
	// field positions
	localparam int FNB_LSB = 4;
	localparam int FNA_LSB = 0;
	localparam int RATE_LSB = 10;
	localparam int STR_LSB = 5;
	localparam int CMB_LSB = 0;
	localparam int PUSH_BIT = 1;
	localparam int LEGACY_BIT = 14;
	localparam int EVEN_LSB = 8;
	localparam int IRQINV_BIT = 14;
	// serial frame
	localparam logic [5:0] PRE_ONES = 6'd32;
	localparam logic [1:0] OP_RD = 2'b10;
	localparam logic [1:0] OP_WR = 2'b01;
	// timebase: 25 ms tick = half period of the fastest blink
	localparam int CLK_NS = 4;
	localparam int TICK_NS = 25_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [3:0] BLINK_TOP = 4'h8;
	localparam logic [4:0] STRETCH_TOP = 5'h10;
	typedef enum logic [4:0] {
		MS_PRE = 5'b00001,
		MS_HDR = 5'b00010,
		MS_TA = 5'b00100,
		MS_RDAT = 5'b01000,
		MS_WDAT = 5'b10000
	} pli_mst_t;
endpackage : pli_pkg

// File: hw/pli_regs.sv
`timescale 1ns/10ps
`default_nettype none
module pli_regs import pli_pkg::*; #(
	parameter logic [4:0] PHY_ADR = 5'h01,
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe_n,
	input wire logic linkSt,
	input wire logic dupSt,
	input wire logic actEv,
	input wire logic colEv,
	input wire logic [7:0] eventIn,
	output logic indicator_out_a,
	output logic indicator_out_b,
	output logic irqOut
);
	localparam int DW = $clog2(TICK_CYCLES + 1);
	localparam logic [DW-1:0] DIV_TOP = DW'(TICK_CYCLES - 1);

	// pin synchronisers
	logic mdcS1_ff, mdcS2_ff, mdcS3_ff, mdioS1_ff, mdioS2_ff;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mdcS1_ff <= 1'b0;
			mdcS2_ff <= 1'b0;
			mdcS3_ff <= 1'b0;
			mdioS1_ff <= 1'b1;
			mdioS2_ff <= 1'b1;
		end else begin
			mdcS1_ff <= mdc;
			mdcS2_ff <= mdcS1_ff;
			mdcS3_ff <= mdcS2_ff;
			mdioS1_ff <= mdioIn;
			mdioS2_ff <= mdioS1_ff;
		end
	end
	logic mdcRise, bitIn;
	assign mdcRise = mdcS2_ff & ~mdcS3_ff;
	assign bitIn = mdioS2_ff;

	// register file state
	logic [15:0] fnSel_ff, behav_ff, drive_ff, legacy_ff;
	logic [7:0] evEn_ff, evSt_ff;
	logic irqInv_ff, irq_ff;
	logic [15:0] nxt_fnSel, nxt_behav, nxt_drive, nxt_legacy, wrDat;
	logic [7:0] nxt_evEn, nxt_evSt;
	logic nxt_irqInv, nxt_irq, wrEn, rdClr;
	logic [4:0] wrAdr;

	function automatic logic [15:0] rdMux(input logic [4:0] a,
		input logic [15:0] f, input logic [15:0] b, input logic [15:0] d,
		input logic [15:0] l, input logic [7:0] e, input logic [7:0] s,
		input logic inv);
		logic [15:0] r;
		r = 16'h0000;
		case (a)
			ADR_FNSEL: r = f;
			ADR_BEHAV: r = b;
			ADR_DRIVE: r = d;
			ADR_LEGACY: r = l;
			ADR_EVENT: r = {e, s};
			ADR_CTRL: r[IRQINV_BIT] = inv;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction : rdMux

	// serial frame engine
	pli_mst_t st_ff, nxt_st;
	logic [5:0] cnt_ff, nxt_cnt;
	logic [15:0] sh_ff, nxt_sh;
	logic opRd_ff, nxt_opRd;
	logic [4:0] reg_ff, nxt_reg;
	logic mdioOut_ff, mdioOeN_ff, nxt_mdioOut, nxt_mdioOeN;
	logic [12:0] hdr;
	logic hdrOk, drv, dBit;
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_opRd = opRd_ff;
		nxt_reg = reg_ff;
		wrEn = 1'b0;
		wrAdr = reg_ff;
		wrDat = {sh_ff[14:0], bitIn};
		rdClr = 1'b0;
		hdr = {sh_ff[11:0], bitIn};
		hdrOk = hdr[12] && hdr[9:5] == PHY_ADR &&
			(hdr[11:10] == OP_RD || hdr[11:10] == OP_WR);
		drv = mdioOeN_ff == 1'b0 || (mdioOut_ff && drive_ff[PUSH_BIT]);
		dBit = mdioOut_ff | mdioOeN_ff;
		if (mdcRise) begin
			case (st_ff)
				MS_PRE: begin
					if (bitIn) begin
						nxt_cnt = (cnt_ff < PRE_ONES) ? cnt_ff + 6'd1 : cnt_ff;
					end else if (cnt_ff == PRE_ONES) begin
						nxt_st = MS_HDR;
						nxt_cnt = 6'd0;
					end else begin
						nxt_cnt = 6'd0;
					end
					drv = 1'b0;
				end
				MS_HDR: begin
					nxt_sh = {sh_ff[14:0], bitIn};
					nxt_cnt = cnt_ff + 6'd1;
					if (cnt_ff == 6'd12) begin
						nxt_cnt = 6'd0;
						nxt_st = hdrOk ? MS_TA : MS_PRE;
						nxt_opRd = hdr[11:10] == OP_RD;
						nxt_reg = hdr[4:0];
						// read data is caught here, so the clear-on-read
						// takes effect before the data leaves the pin
						if (hdrOk && hdr[11:10] == OP_RD) begin
							nxt_sh = rdMux(hdr[4:0], fnSel_ff, behav_ff,
								drive_ff, legacy_ff, evEn_ff, evSt_ff, irqInv_ff);
							rdClr = hdr[4:0] == ADR_EVENT;
						end
					end
					drv = 1'b0;
				end
				MS_TA: begin
					nxt_cnt = cnt_ff + 6'd1;
					drv = opRd_ff;
					dBit = 1'b0;
					if (cnt_ff == 6'd1) begin
						nxt_cnt = 6'd0;
						nxt_st = opRd_ff ? MS_RDAT : MS_WDAT;
						dBit = sh_ff[15];
						nxt_sh = {sh_ff[14:0], 1'b0};
					end
				end
				MS_RDAT: begin
					nxt_cnt = cnt_ff + 6'd1;
					drv = cnt_ff != 6'd15;
					dBit = sh_ff[15];
					nxt_sh = {sh_ff[14:0], 1'b0};
					if (cnt_ff == 6'd15) begin
						nxt_st = MS_PRE;
						nxt_cnt = 6'd0;
					end
				end
				MS_WDAT: begin
					nxt_cnt = cnt_ff + 6'd1;
					nxt_sh = {sh_ff[14:0], bitIn};
					drv = 1'b0;
					if (cnt_ff == 6'd15) begin
						wrEn = 1'b1;
						nxt_st = MS_PRE;
						nxt_cnt = 6'd0;
					end
				end
				default: begin
					nxt_st = MS_PRE;
					nxt_cnt = 6'd0;
					drv = 1'b0;
				end
			endcase
		end
		// open-drain only ever pulls low; push-pull drives both levels
		nxt_mdioOeN = !(drv && (drive_ff[PUSH_BIT] || !dBit));
		nxt_mdioOut = drv && dBit && drive_ff[PUSH_BIT];
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= MS_PRE;
			cnt_ff <= 6'd0;
			sh_ff <= 16'h0000;
			opRd_ff <= 1'b0;
			reg_ff <= 5'h00;
			mdioOut_ff <= 1'b0;
			mdioOeN_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			opRd_ff <= nxt_opRd;
			reg_ff <= nxt_reg;
			mdioOut_ff <= nxt_mdioOut;
			mdioOeN_ff <= nxt_mdioOeN;
		end
	end
	assign mdioOut = mdioOut_ff;
	assign mdioOe_n = mdioOeN_ff;
	// register file; a controller that writes 0 to the mode bit gets
	// extended mode, it is not forced back to 1
	always_comb begin
		nxt_fnSel = fnSel_ff;
		nxt_behav = behav_ff;
		nxt_drive = drive_ff;
		nxt_legacy = legacy_ff;
		nxt_evEn = evEn_ff;
		nxt_irqInv = irqInv_ff;
		if (wrEn) begin
			case (wrAdr)
				ADR_FNSEL: nxt_fnSel = wrDat;
				ADR_BEHAV: nxt_behav = wrDat;
				ADR_DRIVE: nxt_drive = wrDat;
				ADR_LEGACY: nxt_legacy = wrDat;
				ADR_EVENT: nxt_evEn = wrDat[EVEN_LSB +: 8];
				ADR_CTRL: nxt_irqInv = wrDat[IRQINV_BIT];
				default: nxt_irqInv = irqInv_ff;
			endcase
		end
		// set wins over the read clear; bit order follows the
		// enable order 15..8 = status 7..0
		nxt_evSt = (evSt_ff & ~{8{rdClr}}) | eventIn;
		nxt_irq = (|(evSt_ff & evEn_ff)) ^ irqInv_ff;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fnSel_ff <= RST_FNSEL;
			behav_ff <= RST_BEHAV;
			drive_ff <= RST_DRIVE;
			legacy_ff <= RST_LEGACY;
			evEn_ff <= RST_EVEN;
			evSt_ff <= RST_EVST;
			irqInv_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			fnSel_ff <= nxt_fnSel;
			behav_ff <= nxt_behav;
			drive_ff <= nxt_drive;
			legacy_ff <= nxt_legacy;
			evEn_ff <= nxt_evEn;
			evSt_ff <= nxt_evSt;
			irqInv_ff <= nxt_irqInv;
			irq_ff <= nxt_irq;
		end
	end
	assign irqOut = irq_ff;
	// free-running timebase, one tick per 25 ms
	logic [DW-1:0] div_ff, nxt_div;
	logic [3:0] tick_ff, nxt_tick;
	logic tick;
	always_comb begin
		tick = div_ff == DIV_TOP;
		nxt_div = tick ? '0 : div_ff + DW'(1);
		nxt_tick = tick ? tick_ff + 4'd1 : tick_ff;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_ff <= '0;
			tick_ff <= 4'd0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end
	// indicators: 0 = second (b), 1 = first (a); legacy mode behaves as
	// the reset settings, whatever the registers hold
	logic legacy;
	logic [1:0] led;
	assign legacy = legacy_ff[LEGACY_BIT];
	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_ind
		localparam int FN_LSB = (gi == 0) ? FNB_LSB : FNA_LSB;
		localparam int SEL = (gi == 0) ? 1 : 0;
		logic [4:0] str_ff, nxt_str;
		logic led_ff, nxt_led;
		logic [3:0] fn;
		logic [1:0] rate;
		logic strEn, cmbOff, lvl, ev, phase;
		always_comb begin
			fn = legacy ? RST_FNSEL[FN_LSB +: 4] :
				fnSel_ff[FN_LSB +: 4];
			rate = legacy ? RST_BEHAV[RATE_LSB +: 2] :
				behav_ff[RATE_LSB +: 2];
			strEn = !legacy && behav_ff[STR_LSB + SEL];
			cmbOff = !legacy && behav_ff[CMB_LSB + SEL];
			lvl = (fn == 4'h0) ? 1'b0 : (fn[0] ? linkSt : dupSt);
			ev = (fn == 4'h0) ? 1'b0 : (fn[0] ? actEv : colEv);
			// half period 8>>rate ticks, stretch 16>>rate ticks
			phase = |((tick_ff << rate) & BLINK_TOP);
			nxt_str = str_ff;
			if (ev) begin
				nxt_str = STRETCH_TOP >> rate;
			end else if (tick && str_ff != 5'd0) begin
				nxt_str = str_ff - 5'd1;
			end
			if (cmbOff || str_ff == 5'd0) begin
				nxt_led = lvl;
			end else begin
				nxt_led = lvl && !strEn && phase;
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				str_ff <= 5'd0;
				led_ff <= 1'b0;
			end else begin
				str_ff <= nxt_str;
				led_ff <= nxt_led;
			end
		end
		assign led[gi] = led_ff;
	end
	assign indicator_out_b = led[0];
	assign indicator_out_a = led[1];
	property p_rstVal;
		@(posedge clk) sys_rst |=> fnSel_ff == RST_FNSEL &&
			legacy_ff[LEGACY_BIT] && behav_ff[RATE_LSB +: 2] == 2'b00;
	endproperty
	a_rstVal: assert property (p_rstVal) else $error("bad reset");
	property p_rdClr;
		@(posedge clk) disable iff (sys_rst)
		rdClr && eventIn == 8'h00 |=> evSt_ff == 8'h00;
	endproperty
	a_rdClr: assert property (p_rdClr) else $error("no clear");
	// other enabled bits may hold the line, so only the polarity is checked
	property p_setWin;
		@(posedge clk) disable iff (sys_rst)
		eventIn[7] && evEn_ff[7] && !wrEn |=>
			evSt_ff[7] ##1 irqOut != $past(irqInv_ff);
	endproperty
	a_setWin: assert property (p_setWin) else $error("lost set");
	property p_irq;
		@(posedge clk) disable iff (sys_rst)
		(|(evSt_ff & evEn_ff)) && !irqInv_ff |=> irqOut;
	endproperty
	a_irq: assert property (p_irq) else $error("irq low");
	property p_inv;
		@(posedge clk) disable iff (sys_rst)
		!(|(evSt_ff & evEn_ff)) && irqInv_ff |=> irqOut;
	endproperty
	a_inv: assert property (p_inv) else $error("not inverted");
	property p_odr;
		@(posedge clk) disable iff (sys_rst)
		!mdioOe_n && !$past(drive_ff[PUSH_BIT]) |-> !mdioOut;
	endproperty
	a_odr: assert property (p_odr) else $error("drove high");
	property p_legacy;
		@(posedge clk) disable iff (sys_rst)
		legacy && g_ind[1].str_ff == 5'd0 |=>
			indicator_out_a == $past(linkSt);
	endproperty
	a_legacy: assert property (p_legacy) else $error("bad led");
	property p_str;
		@(posedge clk) disable iff (sys_rst)
		!legacy && behav_ff[STR_LSB] && !behav_ff[CMB_LSB] &&
			g_ind[1].str_ff != 5'd0 |=> !indicator_out_a;
	endproperty
	a_str: assert property (p_str) else $error("no stretch");
endmodule : pli_regs
`default_nettype wire

// File: sim/pli_smc.sv
`timescale 1ns/10ps
`default_nettype none
module pli_smc import pli_pkg::*; (
	input wire logic clk,
	input wire logic mdioOut,
	input wire logic mdioOe_n,
	output logic mdc,
	output logic mdioIn
);
	logic drv;
	logic bitM;
	// pulled-up line: whoever lets go reads 1, never a stale bit
	assign mdioIn = (drv ? bitM : 1'b1) & (mdioOe_n ? 1'b1 : mdioOut);
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		bitM = 1'b1;
	end
	// 40 ns per half period; read bits are taken just before the rise
	task automatic clkBit(input logic b, input logic d, output logic s);
		drv <= d;
		bitM <= b;
		repeat (10) @(posedge clk);
		s = mdioIn;
		mdc <= 1'b1;
		repeat (10) @(posedge clk);
		mdc <= 1'b0;
	endtask : clkBit
	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		logic s;
		f = {32'hffffffff, 2'b01, op, 5'h01, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			clkBit(f[i], !(op == OP_RD && i < 18), s);
			if (i < 16) rd[i] = s;
		end
		drv <= 1'b0;
		// let an edge pass so a following frame never reassigns drv at once
		@(posedge clk);
	endtask : frame
endmodule : pli_smc
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import pli_pkg::*;;
	logic clk, rst, mdc, mdioIn, mdioOut, mdioOe_n, ledA, ledB, irqOut;
	logic linkSt, dupSt, actEv, colEv, odMode;
	logic sawPush = 1'b0;
	logic [7:0] eventIn;
	int errTotal, nTests, cyc, la, lb;
	typedef struct packed {
		logic [4:0] a;
		logic [15:0] rv;
		logic [15:0] wv;
		logic [15:0] ev;
	} pli_row_t;
	pli_row_t rows [7] = '{
		'{ADR_FNSEL, 16'h0021, 16'habcd, 16'habcd},
		'{ADR_BEHAV, 16'h1000, 16'h5c63, 16'h5c63},
		'{ADR_LEGACY, 16'h4000, 16'hc000, 16'hc000},
		'{ADR_EVENT, 16'h0000, 16'hff00, 16'hff00},
		'{ADR_CTRL, 16'h0000, 16'hffff, 16'h4000},
		'{5'h18, 16'h0000, 16'hffff, 16'h0000},
		'{ADR_DRIVE, 16'h0000, 16'hffff, 16'hffff}};
	pli_regs #(.PHY_ADR(5'h01), .TICK_CYCLES(8)) pli_regs_i (
		.clk(clk), .sys_rst(rst), .mdc(mdc), .mdioIn(mdioIn),
		.mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .linkSt(linkSt),
		.dupSt(dupSt), .actEv(actEv), .colEv(colEv), .eventIn(eventIn),
		.indicator_out_a(ledA), .indicator_out_b(ledB), .irqOut(irqOut));
	pli_smc pli_smc_i (.clk(clk), .mdioOut(mdioOut),
		.mdioOe_n(mdioOe_n), .mdc(mdc), .mdioIn(mdioIn));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrapUp
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		nTests++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] x;
		pli_smc_i.frame(OP_WR, a, d, x);
	endtask : wrReg
	task automatic rdChk(input logic [4:0] a, input logic [15:0] e,
		input string m);
		logic [15:0] d;
		pli_smc_i.frame(OP_RD, a, 16'h0000, d);
		chk(d, e, m);
	endtask : rdChk
	task automatic pulseEv(input logic [7:0] v);
		eventIn <= v;
		@(posedge clk);
		eventIn <= 8'h00;
		repeat (4) @(posedge clk);
	endtask : pulseEv
	// activity and collision event, then count dark cycles of both
	task automatic watch(input logic [15:0] bv);
		wrReg(ADR_BEHAV, bv);
		{actEv, colEv} <= 2'b11;
		@(posedge clk);
		{actEv, colEv} <= 2'b00;
		la = 0;
		lb = 0;
		repeat (200) begin
			@(posedge clk);
			if (ledA !== 1'b1) la++;
			if (ledB !== 1'b1) lb++;
		end
	endtask : watch
	always @(posedge clk) begin
		if (!mdioOe_n && mdioOut) begin
			sawPush <= 1'b1;
			if (odMode) chk(16'h0001, 16'h0000, "open-drain drove 1");
		end
		cyc++;
		if (cyc == 90000) begin
			errTotal++;
			$display("mismatch at %0t: timeout", $time);
			wrapUp();
		end
	end
	initial begin
		{rst, odMode} = 2'b11;
		{linkSt, dupSt, actEv, colEv} = 4'h0;
		eventIn = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		foreach (rows[i]) begin
			rdChk(rows[i].a, rows[i].rv, "reset");
			if (rows[i].a == ADR_DRIVE) odMode = 1'b0;
			wrReg(rows[i].a, rows[i].wv);
			rdChk(rows[i].a, rows[i].ev, "readback");
		end
		chk(sawPush, 1'b1, "push-pull drive");
		$display("test registers done");
		chk(irqOut, 1'b1, "idle inverted");
		for (int i = 0; i < 8; i++) begin
			pulseEv(8'h01 << i);
			chk(irqOut, 1'b0, "irq raised");
			rdChk(ADR_EVENT, {8'hff, 8'h01 << i}, "status");
			chk(irqOut, 1'b1, "irq after clear");
		end
		wrReg(ADR_CTRL, 16'h0000);
		wrReg(ADR_EVENT, 16'h7f00);
		pulseEv(8'h80);
		chk(irqOut, 1'b0, "masked event");
		wrReg(ADR_EVENT, 16'hff00);
		chk(irqOut, 1'b1, "unmasked event");
		rdChk(ADR_EVENT, 16'hff80, "masked status");
		chk(irqOut, 1'b0, "irq released");
		$display("test events done");
		{linkSt, dupSt} <= 2'b11;
		wrReg(ADR_FNSEL, 16'h0000);
		chk(ledA, 1'b1, "legacy ignores select");
		watch(16'h5c63);
		chk(la > 0, 1'b1, "legacy ignores behaviour");
		wrReg(ADR_LEGACY, 16'h0000);
		chk(ledA, 1'b0, "extended uses select");
		dupSt <= 1'b0;
		wrReg(ADR_FNSEL, 16'h0012);
		chk({ledB, ledA}, 2'b10, "function fields");
		dupSt <= 1'b1;
		watch(16'h0060);
		chk(lb >= 112 && lb <= 136, 1'b1, "stretch 400 ms");
		chk(la >= 112 && la <= 136, 1'b1, "stretch a 400 ms");
		watch(16'h0460);
		chk(lb >= 56 && lb <= 72, 1'b1, "stretch 200 ms");
		watch(16'h0860);
		chk(lb >= 24 && lb <= 40, 1'b1, "stretch 100 ms");
		watch(16'h0c60);
		chk(lb >= 8 && lb <= 20, 1'b1, "stretch 50 ms");
		watch(16'h0000);
		chk(lb >= 40 && lb <= 80, 1'b1, "blink 2.5 Hz");
		chk(la >= 40 && la <= 80, 1'b1, "blink a");
		watch(16'h0003);
		chk(lb, 16'h0000, "combine off");
		chk(la, 16'h0000, "combine off a");
		wrReg(ADR_LEGACY, 16'h4000);
		$display("test indicators done");
		wrapUp();
	end
endmodule : tb
`default_nettype wire
